// ==== logic/sbmsr_defs.vh ====
// constants for the buffer manager control and status register bank
`ifndef SBMSR_DEFS_VH
`define SBMSR_DEFS_VH

// ----------------------------------------
// register indices (plain port address)
// ----------------------------------------
`define SBMSR_ADDR_BCAST_LIMIT 16'h1C04
`define SBMSR_ADDR_DROP_CNT0 16'h1C05
`define SBMSR_ADDR_DROP_CNT1 16'h1C06
`define SBMSR_ADDR_DROP_CNT2 16'h1C07
`define SBMSR_ADDR_INIT_STATUS 16'h1C08
`define SBMSR_ADDR_TBL_CMD 16'h1C09
`define SBMSR_ADDR_TBL_WDATA 16'h1C0A
`define SBMSR_ADDR_TBL_RDATA 16'h1C0B

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define SBMSR_BCAST_LIMIT_RST 8'h31
`define SBMSR_CMD_RNW_BIT 4
`define SBMSR_CNT_MAX 32'hFFFFFFFF
`define SBMSR_CNT_ZERO 32'h00000000
`define SBMSR_CNT_ONE 32'h00000001

// ----------------------------------------
// usage range bounds of the weight table
// ----------------------------------------
`define SBMSR_USAGE_TIER1 8'h40
`define SBMSR_USAGE_TIER2 8'h80

`endif

// ==== logic/sbmsr_switch_buffer_mgr_status_regs.v ====
// buffer manager control and status register bank with discard weight table
// ----------------------------------------
// Operation
// - broadcast buffer limit, 8 bits, reset 31h
// - one 32-bit drop counter per port
// - count space-limit, red and yellow drops
// - reading a counter returns and clears it
// - counters saturate at all ones
// - weight table not initialized on fabric reset; only the init time is counted
// - ready flag low after reset, self-sets
// - command write starts table access immediately
// - bit 4 selects read(1) or write(0)
// - bits 3:0 select one of 16 entries
// - usage ranges 8, 16, 32 buffers wide
// - read command loads entry into read data
// - entries hold 10-bit drop probability
// ----------------------------------------
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`include "sbmsr_defs.vh"

module sbmsr_switch_buffer_mgr_status_regs #(
	parameter NPORTS = 3,
	parameter ENTRY_W = 10,
	parameter INIT_CYCLES = 16,
	// saturation point of the drop counters; a bench may lower it to reach it quickly
	parameter [31:0] CNT_MAX = `SBMSR_CNT_MAX
) (
	// clock and reset
	input wire refClk,
	input wire nrst,
	// register port
	input wire [15:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrStrobe,
	input wire regRdStrobe,
	output reg [31:0] regRdData,
	// drop events from the datapath, one bit per ingress port
	input wire [NPORTS-1:0] spaceDrop,
	input wire [NPORTS-1:0] redDrop,
	input wire [NPORTS-1:0] yellowDrop,
	// weight lookup for the random discard logic
	input wire [7:0] ingressUsage,
	output reg [ENTRY_W-1:0] yellowDropProb,
	// configuration and status to the fabric
	output wire [7:0] bcastLimit,
	output wire tablesInitializedFlag
);

	// ----------------------------------------
	// broadcast limit
	// ----------------------------------------
	reg [7:0] bcastLimitReg;
	assign bcastLimit = bcastLimitReg;
	always @(posedge refClk or negedge nrst) begin
		if (!nrst) begin
			bcastLimitReg <= `SBMSR_BCAST_LIMIT_RST;
		end else if (regWrStrobe && regAddr == `SBMSR_ADDR_BCAST_LIMIT) begin
			bcastLimitReg <= regWrData[7:0];
		end
	end

	// ----------------------------------------
	// per port drop counters
	// ----------------------------------------
	wire [31:0] dropCnt [0:NPORTS-1];
	genvar gi;
	generate
		for (gi = 0; gi < NPORTS; gi = gi + 1) begin : gCnt
			reg [31:0] cnt;
			wire hit = spaceDrop[gi] | redDrop[gi] | yellowDrop[gi];
			wire clr = regRdStrobe && (regAddr == `SBMSR_ADDR_DROP_CNT0 + gi);
			assign dropCnt[gi] = cnt;
			always @(posedge refClk or negedge nrst) begin
				if (!nrst) begin
					cnt <= `SBMSR_CNT_ZERO;
				end else if (clr) begin
					// an event in the clearing cycle survives as a count of one
					cnt <= hit ? `SBMSR_CNT_ONE : `SBMSR_CNT_ZERO;
				end else if (hit && cnt != CNT_MAX) begin
					cnt <= cnt + `SBMSR_CNT_ONE;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// initialization sequence after reset
	// ----------------------------------------
	reg [7:0] initCnt;
	reg ready;
	assign tablesInitializedFlag = ready;
	always @(posedge refClk or negedge nrst) begin
		if (!nrst) begin
			initCnt <= 8'h00;
			ready <= 1'b0;
		end else if (!ready) begin
			// walk the table-init time; the weight table itself is left alone
			if (initCnt == INIT_CYCLES[7:0] - 8'h01) begin
				ready <= 1'b1;
			end
			initCnt <= initCnt + 8'h01;
		end
	end

	// ----------------------------------------
	// discard weight table and its commands
	// ----------------------------------------
	reg [ENTRY_W-1:0] weightTable [0:15];
	reg [4:0] cmdReg;
	reg [ENTRY_W-1:0] wrDataReg;
	reg [ENTRY_W-1:0] rdDataReg;
	wire cmdWrite = regWrStrobe && regAddr == `SBMSR_ADDR_TBL_CMD;

	always @(posedge refClk or negedge nrst) begin
		if (!nrst) begin
			cmdReg <= 5'h00;
			wrDataReg <= {ENTRY_W{1'b0}};
			rdDataReg <= {ENTRY_W{1'b0}};
		end else begin
			if (regWrStrobe && regAddr == `SBMSR_ADDR_TBL_WDATA) begin
				wrDataReg <= regWrData[ENTRY_W-1:0];
			end
			if (cmdWrite) begin
				cmdReg <= regWrData[4:0];
				if (regWrData[`SBMSR_CMD_RNW_BIT]) begin
					rdDataReg <= weightTable[regWrData[3:0]];
				end
			end
		end
	end

	// no reset on the table: software must fill it before use
	always @(posedge refClk) begin
		if (cmdWrite && !regWrData[`SBMSR_CMD_RNW_BIT]) begin
			weightTable[regWrData[3:0]] <= wrDataReg;
		end
	end

	// ----------------------------------------
	// usage to index mapping for lookup
	// ----------------------------------------
	reg [3:0] usageIdx;
	always @* begin
		if (ingressUsage < `SBMSR_USAGE_TIER1) begin
			usageIdx = {1'b0, ingressUsage[5:3]};
		end else if (ingressUsage < `SBMSR_USAGE_TIER2) begin
			usageIdx = {2'b10, ingressUsage[5:4]};
		end else begin
			usageIdx = {2'b11, ingressUsage[6:5]};
		end
	end

	always @(posedge refClk or negedge nrst) begin
		if (!nrst) begin
			yellowDropProb <= {ENTRY_W{1'b0}};
		end else begin
			yellowDropProb <= weightTable[usageIdx];
		end
	end

	// ----------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------
	reg [31:0] next_regRdData;
	always @* begin
		next_regRdData = 32'h00000000;
		case (regAddr)
			`SBMSR_ADDR_BCAST_LIMIT: next_regRdData = {24'h000000, bcastLimitReg};
			`SBMSR_ADDR_DROP_CNT0: next_regRdData = dropCnt[0];
			`SBMSR_ADDR_DROP_CNT1: next_regRdData = dropCnt[1];
			`SBMSR_ADDR_DROP_CNT2: next_regRdData = dropCnt[2];
			`SBMSR_ADDR_INIT_STATUS: next_regRdData = {31'h00000000, ready};
			`SBMSR_ADDR_TBL_CMD: next_regRdData = {27'h0000000, cmdReg};
			`SBMSR_ADDR_TBL_WDATA: next_regRdData = {{(32-ENTRY_W){1'b0}}, wrDataReg};
			`SBMSR_ADDR_TBL_RDATA: next_regRdData = {{(32-ENTRY_W){1'b0}}, rdDataReg};
			default: next_regRdData = 32'h00000000;
		endcase
	end

	always @(posedge refClk or negedge nrst) begin
		if (!nrst) begin
			regRdData <= 32'h00000000;
		end else if (regRdStrobe) begin
			regRdData <= next_regRdData;
		end else begin
			regRdData <= 32'h00000000;
		end
	end

endmodule // sbmsr_switch_buffer_mgr_status_regs

// ==== tb/sbmsr_checker.sv ====
// checker for the buffer manager register bank
`timescale 1ns/1ns
module sbmsr_checker #(parameter NPORTS = 3) (
	input wire refClk, nrst, regWrStrobe, regRdStrobe, tablesInitializedFlag,
	input wire [15:0] regAddr,
	input wire [31:0] regWrData, regRdData,
	input wire [NPORTS-1:0] spaceDrop, redDrop, yellowDrop,
	input wire [7:0] bcastLimit
);
	wire [NPORTS-1:0] d = spaceDrop | redDrop | yellowDrop;
	wire r0 = regRdStrobe && regAddr == 16'h1C05;
	wire r1 = regRdStrobe && regAddr == 16'h1C06;
	wire wB = regWrStrobe && regAddr == 16'h1C04;
	wire wC = regWrStrobe && regAddr == 16'h1C09;
	default clocking @(posedge refClk); endclocking
	default disable iff (!nrst);
	idle_zero_a: assert property (
		!$past(regRdStrobe) |-> regRdData == 0) else $error("stray read data");
	flag_stays_a: assert property (
		tablesInitializedFlag |=> tablesInitializedFlag) else $error("flag dropped");
	limit_set_a: assert property (
		wB |=> bcastLimit == $past(regWrData[7:0])) else $error("limit not written");
	limit_hold_a: assert property (
		!wB |=> $stable(bcastLimit)) else $error("limit moved");
	read_clear_a: assert property (
		r0 && !d[0] ##1 !d[0] ##1 r0 |=> regRdData == 0) else $error("not cleared");
	drop_kept_a: assert property (
		r1 && d[1] ##1 !d[1] ##1 r1 |=> regRdData == 1) else $error("drop lost");
	flag_read_a: assert property (
		regRdStrobe && regAddr == 16'h1C08 |=> regRdData == $past(tablesInitializedFlag))
		else $error("flag read");
	cmd_back_a: assert property (
		wC ##1 !wC ##1 regRdStrobe && regAddr == 16'h1C09
		|=> regRdData == $past(regWrData[4:0], 3)) else $error("command readback");
endmodule // sbmsr_checker

// ==== tb/sbmsr_switch_buffer_mgr_status_regs_bench.sv ====
// bench for the buffer manager register bank
`timescale 1ns/1ns
module sbmsr_switch_buffer_mgr_status_regs_bench;
	reg refClk = 0, nrst = 0, regWrStrobe = 0, regRdStrobe = 0;
	reg [15:0] regAddr = 0;
	reg [31:0] regWrData = 0;
	reg [2:0] spaceDrop = 0, redDrop = 0, yellowDrop = 0;
	reg [7:0] ingressUsage = 0;
	wire [31:0] regRdData;
	wire [9:0] yellowDropProb;
	wire [7:0] bcastLimit;
	wire tablesInitializedFlag;
	int n_fail = 0, compares = 0, i;
	always #5 refClk = ~refClk;
	sbmsr_switch_buffer_mgr_status_regs #(.INIT_CYCLES(4), .CNT_MAX(32'h0000000F))
		u_sbmsr_switch_buffer_mgr_status_regs (.*);
	task chk(string n, logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(logic [15:0] a, logic [31:0] d);
		@(posedge refClk) {regAddr, regWrData, regWrStrobe} <= {a, d, 1'h1};
		@(posedge refClk) regWrStrobe <= 0;
	endtask
	// drops ride on reads so each pattern lasts exactly one cycle
	task rd(logic [15:0] a, logic [31:0] e, logic [8:0] p = 0);
		@(posedge refClk) {regAddr, regRdStrobe, spaceDrop, redDrop, yellowDrop} <= {a, 1'h1, p};
		@(posedge refClk) {regRdStrobe, spaceDrop, redDrop, yellowDrop} <= 10'h000;
		#1 chk("read data", regRdData, e);
	endtask
	task t_reset;
		@(posedge refClk) nrst <= 0;
		repeat (2) @(posedge refClk);
		nrst <= 1;
		rd(16'h1C08, 0);
		chk("ready", tablesInitializedFlag, 0);
		rd(16'h1C04, 32'h31);
		for (i = 5; i < 9; i++) rd(16'h1C00 + i, i / 8);
		chk("ready", tablesInitializedFlag, 1);
		wr(16'h1C04, 32'hFFFFFF5A);
		wr(16'h1C05, 32'h7);
		rd(16'h1C05, 0);
		chk("limit", bcastLimit, 32'h5A);
		rd(16'h1C04, 32'h5A);
		$display("reset test done");
	endtask
	task t_drops;
		rd(16'h1C0C, 0, 9'h054);
		rd(16'h1C0C, 0, 9'h0A1);
		rd(16'h1C0C, 0, 9'h1FF);
		rd(16'h1C05, 3);
		rd(16'h1C05, 0);
		rd(16'h1C06, 3, 9'h010);
		rd(16'h1C06, 1);
		rd(16'h1C07, 3);
		$display("drop test done");
	endtask
	// counters are built with a low ceiling here so the stop is reachable
	task t_saturate;
		for (i = 0; i < 20; i++) rd(16'h1C0C, 0, 9'h1FF);
		rd(16'h1C05, 32'hF);
		rd(16'h1C06, 32'hF);
		rd(16'h1C07, 32'hF);
		rd(16'h1C07, 0);
		$display("saturate test done");
	endtask
	task t_table;
		for (i = 0; i < 16; i++) begin
			wr(16'h1C0A, 512 + 31 * i);
			wr(16'h1C09, i);
			wr(16'h1C09, 16 + i);
			rd(16'h1C09, 16 + i);
			rd(16'h1C0B, 512 + 31 * i);
		end
		for (i = 0; i < 256; i++) begin
			@(posedge refClk) ingressUsage <= i[7:0];
			@(posedge refClk) #1 chk("weight", yellowDropProb,
				512 + 31 * (i < 64 ? i / 8 : i < 128 ? 4 + i / 16 : 8 + i / 32));
		end
		$display("table test done");
	endtask
	task conclude;
		$display("%0d checks, %0d wrong", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		t_reset;
		t_drops;
		t_saturate;
		t_table;
		t_reset;
		conclude;
	end
endmodule // sbmsr_switch_buffer_mgr_status_regs_bench
bind sbmsr_switch_buffer_mgr_status_regs sbmsr_checker #(.NPORTS(NPORTS))
	u_sbmsr_checker (.*);
